// [shared/tdp_pkg.sv]
// Purpose: Constants and types for the transceiver diagnostic serial port.
// Assumes: One 20 MHz clock; serial pins are sampled, never used as clocks.
// Notes:   The threshold and status offsets are fixed here only.
package tdp_pkg;
  localparam logic [6:0]  ID_ADDR    = 7'h50;
  localparam logic [6:0]  DIAG_ADDR  = 7'h51;
  localparam logic [7:0]  THR_END    = 8'h27;
  localparam logic [7:0]  LIVE_BASE  = 8'h60;
  localparam logic [7:0]  LIVE_END   = 8'h69;
  localparam logic [7:0]  STAT_ADDR  = 8'h6e;
  localparam logic [7:0]  ALM_ADDR   = 8'h70;
  localparam logic [7:0]  ALM2_ADDR  = 8'h71;
  localparam logic [7:0]  WRN_ADDR   = 8'h74;
  localparam logic [7:0]  WRN2_ADDR  = 8'h75;
  localparam int          STAT_PIN   = 7;
  localparam int          STAT_SOFT  = 6;
  localparam int          STAT_FAULT = 2;
  localparam int          STAT_LOS   = 1;
  localparam logic [15:0] THR_AHI    = 16'hf000;
  localparam logic [15:0] THR_ALO    = 16'h1000;
  localparam logic [15:0] THR_WHI    = 16'he000;
  localparam logic [15:0] THR_WLO    = 16'h2000;
  // Arbitrary contents of the first two protected identification bytes.
  localparam logic [7:0]  ID_BYTE0   = 8'h03;
  localparam logic [7:0]  ID_BYTE1   = 8'h04;
  localparam int          LIVE_N     = 5;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [4:0]  SYNC_RST   = 5'h03;

  typedef enum {
    ST_IDLE, ST_RX, ST_RXDONE, ST_ACK, ST_TX, ST_TXDONE, ST_MACK, ST_MACKED
  } tdp_state_e;

  typedef enum {PH_ADDR, PH_WADDR, PH_DATA} tdp_phase_e;
endpackage : tdp_pkg

// [shared/tdp_mem_if.sv]
// Purpose: Carries memory access and pin status between port engine and memory.
// Assumes: All signals are on clock_i.
// Notes:   The write strobe is combinational and lasts one cycle.
interface tdp_mem_if;
  logic       dev_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;
  logic       txdis_pin;
  logic       tx_fault;
  logic       rx_los;
  logic       soft_txdis;

  modport ctl (output dev_sel, addr, wdata, we, txdis_pin, tx_fault, rx_los,
               input  rdata, soft_txdis);
  modport mem (input  dev_sel, addr, wdata, we, txdis_pin, tx_fault, rx_los,
               output rdata, soft_txdis);
endinterface : tdp_mem_if

// [rtl/tdp_mem.sv]
// Purpose: Identification and diagnostic memory spaces with alarm flags.
// Assumes: Live values come from the diagnostics controller on clock_i.
// Notes:   Thresholds are factory constants and cannot be written.
module tdp_mem
  import tdp_pkg::*;
(
  // Clock and reset
  input  logic                          clock_i,
  input  logic                          rst_i,
  // Access port
  tdp_mem_if.mem                        bus,
  // Calibrated live values
  input  logic [LIVE_N-1:0][15:0]       live_i
);
  logic [7:0]  idu_r [128];
  logic [7:0]  idu_nxt [128];
  logic [7:0]  dgu_r [128];
  logic [7:0]  dgu_nxt [128];
  logic        soft_r;
  logic        soft_nxt;
  logic [15:0] alm_r;
  logic [15:0] alm_nxt;
  logic [15:0] wrn_r;
  logic [15:0] wrn_nxt;
  logic [7:0]  off;

  function automatic logic [1:0] chk(input logic [15:0] v, input logic [15:0] hi, input logic [15:0] lo);
    return {v > hi, v < lo};
  endfunction : chk

  function automatic logic [7:0] thr_byte(input logic [7:0] a);
    logic [15:0] t;
    case (a[2:1])
      2'h0:    t = THR_AHI;
      2'h1:    t = THR_ALO;
      2'h2:    t = THR_WHI;
      default: t = THR_WLO;
    endcase
    return a[0] ? t[7:0] : t[15:8];
  endfunction : thr_byte

  always_comb begin
    idu_nxt  = idu_r;
    dgu_nxt  = dgu_r;
    soft_nxt = soft_r;
    alm_nxt  = '0;
    wrn_nxt  = '0;
    // Lower halves are protected; only the upper halves and the soft disable take data.
    if (bus.we && bus.addr[7]) begin
      if (bus.dev_sel)
        dgu_nxt[bus.addr[6:0]] = bus.wdata;
      else
        idu_nxt[bus.addr[6:0]] = bus.wdata;
    end
    if (bus.we && bus.dev_sel && bus.addr == STAT_ADDR)
      soft_nxt = bus.wdata[STAT_SOFT];
    for (int i = 0; i < LIVE_N; i++) begin
      alm_nxt[15-2*i -: 2] = chk(live_i[i], THR_AHI, THR_ALO);
      wrn_nxt[15-2*i -: 2] = chk(live_i[i], THR_WHI, THR_WLO);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        idu_r[i] <= 8'h00;
        dgu_r[i] <= 8'h00;
      end
      soft_r <= 1'b0;
      alm_r  <= 16'h0000;
      wrn_r  <= 16'h0000;
    end else begin
      idu_r  <= idu_nxt;
      dgu_r  <= dgu_nxt;
      soft_r <= soft_nxt;
      alm_r  <= alm_nxt;
      wrn_r  <= wrn_nxt;
    end
  end

  assign off = bus.addr - LIVE_BASE;
  assign bus.soft_txdis = soft_r;

  always_comb begin
    bus.rdata = 8'h00;
    if (!bus.dev_sel) begin
      if (bus.addr[7])
        bus.rdata = idu_r[bus.addr[6:0]];
      else if (bus.addr == 8'h00)
        bus.rdata = ID_BYTE0;
      else if (bus.addr == 8'h01)
        bus.rdata = ID_BYTE1;
    end else if (bus.addr[7]) begin
      bus.rdata = dgu_r[bus.addr[6:0]];
    end else if (bus.addr <= THR_END) begin
      bus.rdata = thr_byte(bus.addr);
    end else if (bus.addr >= LIVE_BASE && bus.addr <= LIVE_END) begin
      // Values are passed through untouched because the controller calibrates them.
      bus.rdata = off[0] ? live_i[off[3:1]][7:0] : live_i[off[3:1]][15:8];
    end else begin
      case (bus.addr)
        STAT_ADDR: begin
          bus.rdata[STAT_PIN]   = bus.txdis_pin;
          bus.rdata[STAT_SOFT]  = soft_r;
          bus.rdata[STAT_FAULT] = bus.tx_fault;
          bus.rdata[STAT_LOS]   = bus.rx_los;
        end
        ALM_ADDR:  bus.rdata = alm_r[15:8];
        ALM2_ADDR: bus.rdata = alm_r[7:0];
        WRN_ADDR:  bus.rdata = wrn_r[15:8];
        WRN2_ADDR: bus.rdata = wrn_r[7:0];
        default:   bus.rdata = 8'h00;
      endcase
    end
  end
endmodule : tdp_mem

// [rtl/tdp_top.sv]
// Purpose: Two-wire serial slave serving identification and diagnostic spaces.
// Assumes: Serial clock is slow against clock_i, at least four cycles per half.
// Notes:   Serial pins are sampled; edges are found from the synchronised copies.
module tdp_top
  import tdp_pkg::*;
(
  // Clock and reset
  input  logic                    clock_i,
  input  logic                    rst_i,
  // Two-wire serial port
  input  logic                    scl_i,
  input  logic                    sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n_o,
  // Transmitter control and status pins
  input  logic                    tx_disable_pin_i,
  input  logic                    tx_fault_i,
  input  logic                    rx_los_i,
  output logic                    tx_off_o,
  // Calibrated live values from the diagnostics controller
  input  logic [LIVE_N-1:0][15:0] live_i
);
  tdp_mem_if  mif ();

  logic [4:0] sy1_r;
  logic [4:0] sy1_nxt;
  logic [4:0] sy2_r;
  logic [4:0] sy2_nxt;
  logic [1:0] q_r;
  logic [1:0] q_nxt;
  tdp_state_e st_r;
  tdp_state_e st_nxt;
  tdp_phase_e ph_r;
  tdp_phase_e ph_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       sel_r;
  logic       sel_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       off_r;
  logic       off_nxt;
  logic       we_c;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // The serial clock is only sampled and never driven from this side.
  always_comb begin
    sy1_nxt = {rx_los_i, tx_fault_i, tx_disable_pin_i, sda_i, scl_i};
    sy2_nxt = sy1_r;
    q_nxt   = sy2_r[1:0];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
      q_r   <= 2'h3;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
      q_r   <= q_nxt;
    end
  end

  assign scl_rise = sy2_r[0] & ~q_r[0];
  assign scl_fall = ~sy2_r[0] & q_r[0];
  assign start_c  = sy2_r[0] & q_r[0] & q_r[1] & ~sy2_r[1];
  assign stop_c   = sy2_r[0] & q_r[0] & ~q_r[1] & sy2_r[1];

  always_comb begin
    st_nxt   = st_r;
    ph_nxt   = ph_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    sel_nxt  = sel_r;
    rw_nxt   = rw_r;
    oe_n_nxt = oe_n_r;
    we_c     = 1'b0;
    off_nxt  = sy2_r[2] | mif.soft_txdis;
    if (start_c) begin
      st_nxt   = ST_RX;
      ph_nxt   = PH_ADDR;
      cnt_nxt  = 3'h0;
      oe_n_nxt = 1'b1;
    end else if (stop_c) begin
      st_nxt   = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        ST_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sy2_r[1]};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == BIT_LAST)
              st_nxt = ST_RXDONE;
          end
        end
        ST_RXDONE: begin
          if (scl_fall) begin
            st_nxt   = ST_ACK;
            oe_n_nxt = 1'b0;
            case (ph_r)
              PH_ADDR: begin
                if (sh_r[7:1] == ID_ADDR || sh_r[7:1] == DIAG_ADDR) begin
                  sel_nxt = sh_r[1];
                  rw_nxt  = sh_r[0];
                end else begin
                  st_nxt   = ST_IDLE;
                  oe_n_nxt = 1'b1;
                end
              end
              PH_WADDR: addr_nxt = sh_r;
              default: begin
                we_c     = 1'b1;
                addr_nxt = addr_r + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (ph_r == PH_ADDR && rw_r) begin
              sh_nxt   = mif.rdata;
              oe_n_nxt = mif.rdata[7];
              addr_nxt = addr_r + 8'h01;
              st_nxt   = ST_TX;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt   = ST_RX;
              ph_nxt   = (ph_r == PH_ADDR) ? PH_WADDR : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            sh_nxt   = {sh_r[6:0], 1'b0};
            oe_n_nxt = sh_r[6];
          end
          if (scl_rise) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == BIT_LAST)
              st_nxt = ST_TXDONE;
          end
        end
        ST_TXDONE: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b1;
            st_nxt   = ST_MACK;
          end
        end
        ST_MACK: begin
          // A missing acknowledge ends the burst; the host then sends stop.
          if (scl_rise)
            st_nxt = sy2_r[1] ? ST_IDLE : ST_MACKED;
        end
        ST_MACKED: begin
          if (scl_fall) begin
            sh_nxt   = mif.rdata;
            oe_n_nxt = mif.rdata[7];
            addr_nxt = addr_r + 8'h01;
            cnt_nxt  = 3'h0;
            st_nxt   = ST_TX;
          end
        end
        default: begin
          st_nxt   = ST_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r   <= ST_IDLE;
      ph_r   <= PH_ADDR;
      cnt_r  <= 3'h0;
      sh_r   <= 8'h00;
      addr_r <= 8'h00;
      sel_r  <= 1'b0;
      rw_r   <= 1'b0;
      oe_n_r <= 1'b1;
      off_r  <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      ph_r   <= ph_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      addr_r <= addr_nxt;
      sel_r  <= sel_nxt;
      rw_r   <= rw_nxt;
      oe_n_r <= oe_n_nxt;
      off_r  <= off_nxt;
    end
  end

  assign mif.dev_sel   = sel_r;
  assign mif.addr      = addr_r;
  assign mif.wdata     = sh_r;
  assign mif.we        = we_c;
  assign mif.txdis_pin = sy2_r[2];
  assign mif.tx_fault  = sy2_r[3];
  assign mif.rx_los    = sy2_r[4];

  // The line is open drain, so the driven level is always low.
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = oe_n_r;
  assign tx_off_o   = off_r;

  tdp_mem u_mem (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .bus     (mif.mem),
    .live_i  (live_i)
  );
endmodule : tdp_top

// [test/tdp_checker.sv]
// Purpose: Port-level assertions for the diagnostic serial port.
// Assumes: Serial clock halves last at least four clock cycles.
// Notes:   The data drive is judged by sda_oe_n_o; sda_i only marks start and stop.
module tdp_checker
  import tdp_pkg::*;
(
  // Clock, reset and serial pins
  input logic                    clock_i,
  input logic                    rst_i,
  input logic                    scl_i,
  input logic                    sda_i,
  input logic                    sda_o,
  input logic                    sda_oe_n_o,
  // Status pins and live values
  input logic                    tx_disable_pin_i,
  input logic                    tx_fault_i,
  input logic                    rx_los_i,
  input logic                    tx_off_o,
  input logic [LIVE_N-1:0][15:0] live_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence

  a_pin_low_only: assert property (sda_o == 1'b0)
    else $error("data pin drives a high level");
  a_released_after_reset: assert property ($fell(rst_i) |-> sda_oe_n_o)
    else $error("data line held after reset");
  a_change_clock_low: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i) && !$past(scl_i, 2))
    else $error("data drive changed while serial clock high");
  a_drive_over_rise: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o throughout (##[1:40] $rose(scl_i)))
    else $error("data drive dropped before the serial clock rose");
  a_drive_span: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*3])
    else $error("data drive shorter than three cycles");
  a_start_released: assert property (s_start |-> sda_oe_n_o [*4])
    else $error("data line driven at a start");
  a_stop_released: assert property (s_stop |-> ##1 sda_oe_n_o [*8])
    else $error("data line driven after a stop");
  a_pin_disables: assert property (tx_disable_pin_i |-> ##3 tx_off_o)
    else $error("transmitter not off with disable pin high");
endmodule : tdp_checker

bind tdp_top tdp_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .tx_disable_pin_i(tx_disable_pin_i), .tx_fault_i(tx_fault_i),
  .rx_los_i(rx_los_i), .tx_off_o(tx_off_o), .live_i(live_i)
);

// [test/tdp_host.sv]
// Purpose: Two-wire bus master standing in for the host board.
// Assumes: Bit period 400 ns; the data line has a pull-up on the board.
// Notes:   The serial clock rests high between frames and never runs free.
module tdp_host (
  // Wire levels
  input  logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 100;
  logic [7:0] rd_d;
  event       got;

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic bitx(input logic b, output logic r);
    sda_low_o = !b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : bitx

  task automatic start();
    // Offset keeps the link edges away from the system clock edges.
    #37 sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #(2 * Q);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte

  task automatic rbyte(input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, rd_d[i]);
    bitx(last, r);
    ->got;
  endtask : rbyte
endmodule : tdp_host

// [test/test_tdp_top.sv]
// Purpose: Self-checking bench for the diagnostic serial port top.
// Assumes: The host model owns the serial clock; the data line is pulled up.
// Notes:   Read bytes are compared in order against a queue of notes.
module test_tdp_top
  import tdp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clock_i, rst_i, scl, host_low, sda_w, sda_o, sda_oe_n_o;
  logic                    tx_off_o, pin_dis, fault, los, ack;
  logic [LIVE_N-1:0][15:0] live;
  logic [7:0]              exp_q[$];
  logic [7:0]              rnd_a, rnd_b;
  logic [63:0]             thr_all = {THR_AHI, THR_ALO, THR_WHI, THR_WLO};
  int                      seed = 32'h0dbf89f9;
  int                      fails = 0;
  int                      compares = 0;

  assign sda_w = !(host_low || (!sda_oe_n_o && !sda_o));

  tdp_top uut (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .tx_disable_pin_i(pin_dis), .tx_fault_i(fault),
    .rx_los_i(los), .tx_off_o(tx_off_o), .live_i(live)
  );
  tdp_host host (.sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic e, input logic g);
    chk_byte({7'h00, e}, {7'h00, g});
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask : tick

  task automatic note(input logic [7:0] e);
    exp_q.push_back(e);
  endtask : note

  task automatic head(input logic [6:0] dev, input logic [7:0] wa);
    host.start();
    host.wbyte({dev, 1'b0}, ack);
    chk_bit(1'b1, ack);
    host.wbyte(wa, ack);
    chk_bit(1'b1, ack);
  endtask : head

  task automatic rd(input logic [6:0] dev, input logic [7:0] wa, input int n);
    head(dev, wa);
    host.start();
    host.wbyte({dev, 1'b1}, ack);
    chk_bit(1'b1, ack);
    for (int i = 0; i < n; i++) host.rbyte(i == n - 1);
    host.stop();
    tick(2);
  endtask : rd

  task automatic wr(input logic [6:0] dev, input logic [7:0] wa, input logic [15:0] d, input int n);
    head(dev, wa);
    for (int i = 0; i < n; i++) begin
      host.wbyte(d[15-8*i -: 8], ack);
      chk_bit(1'b1, ack);
    end
    host.stop();
    tick(2);
  endtask : wr

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  initial forever begin
    @(host.got);
    chk_byte(exp_q.pop_front(), host.rd_d);
  end

  initial begin
    #2_000_000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1;
    pin_dis = 1'b0;
    fault = 1'b0;
    los = 1'b0;
    for (int i = 0; i < LIVE_N; i++) live[i] = 16'h2000 + 16'($random(seed) & 32'h7fff);
    tick(5);
    rst_i = 1'b0;
    tick(6);
    chk_bit(1'b0, tx_off_o);
    note(ID_BYTE0);
    note(ID_BYTE1);
    rd(ID_ADDR, 8'h00, 2);
    // The top bit is forced so the attempted value always differs from the protected byte.
    rnd_a = 8'($random(seed)) | 8'h80;
    wr(ID_ADDR, 8'h00, {rnd_a, rnd_a}, 1);
    note(ID_BYTE0);
    rd(ID_ADDR, 8'h00, 1);
    rnd_a = 8'($random(seed));
    rnd_b = 8'($random(seed));
    wr(ID_ADDR, 8'hfe, {rnd_a, rnd_b}, 2);
    wr(DIAG_ADDR, 8'hff, {~rnd_b, ~rnd_b}, 1);
    note(rnd_b);
    note(ID_BYTE0);
    rd(ID_ADDR, 8'hff, 2);
    for (int i = 0; i < 2 * LIVE_N; i++) note(i[0] ? live[i/2][7:0] : live[i/2][15:8]);
    rd(DIAG_ADDR, LIVE_BASE, 2 * LIVE_N);
    for (int i = 0; i < 8; i++) note(thr_all[63-8*i -: 8]);
    rd(DIAG_ADDR, 8'h18, 8);
    live[0] = 16'hf800;
    live[1] = 16'h1800;
    tick(2);
    for (int i = 0; i < 6; i++) note(i == 0 ? 8'h80 : (i == 4 ? 8'h90 : 8'h00));
    rd(DIAG_ADDR, ALM_ADDR, 6);
    fault = 1'b1;
    los = 1'b1;
    tick(4);
    note(8'h06);
    rd(DIAG_ADDR, STAT_ADDR, 1);
    wr(DIAG_ADDR, STAT_ADDR, 16'h4040, 1);
    chk_bit(1'b1, tx_off_o);
    note(8'h46);
    rd(DIAG_ADDR, STAT_ADDR, 1);
    rst_i = 1'b1;
    tick(5);
    rst_i = 1'b0;
    tick(6);
    chk_bit(1'b0, tx_off_o);
    wr(DIAG_ADDR, STAT_ADDR, 16'h0000, 1);
    chk_bit(1'b0, tx_off_o);
    pin_dis = 1'b1;
    tick(4);
    chk_bit(1'b1, tx_off_o);
    note(8'h86);
    rd(DIAG_ADDR, STAT_ADDR, 1);
    for (int i = 0; i < 4; i++) begin
      rnd_a = 8'($random(seed));
      if (rnd_a[6:1] == 6'h28) rnd_a[6] = ~rnd_a[6];
      host.start();
      host.wbyte({rnd_a[6:0], 1'b0}, ack);
      chk_bit(1'b0, ack);
      host.stop();
      tick(1);
    end
    tick(4);
    chk_byte(8'h00, 8'(exp_q.size()));
    report_and_stop();
  end
endmodule : test_tdp_top
